/* File: fpi_panel.sv */
module fpi_panel
    import fpi_pkg::*;
#(
    parameter longint unsigned SRV_TEST = SRV_TEST_CYC,
    parameter longint unsigned BRG_TEST = BRG_TEST_CYC,
    parameter int unsigned FLASH = FLASH_CYC,
    parameter int unsigned BLINK = BLINK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // status sources
    input wire logic pkt_seen,
    input wire logic ring_inserted,
    input wire logic pkt_own_addr,
    input wire logic port_rx,
    input wire logic pkt_fwd_decision,
    input wire logic pkt_forwarded,
    input wire logic boot_active,
    input wire logic diag_fail,
    input wire logic ctrl_board_fail,
    input wire logic no_boot_source,
    input wire logic disk_access,
    // lamps
    output logic lamp_traffic,
    output logic lamp_accepted,
    output logic lamp_port_rx,
    output logic lamp_forwarded,
    output logic lamp_boot,
    output logic lamp_self_test,
    output logic lamp_disk
);
    localparam int unsigned FW = $clog2(FLASH + 1);
    localparam int unsigned BW = $clog2(BLINK + 1);
    localparam int unsigned TW = $clog2((BRG_TEST > SRV_TEST ? BRG_TEST : SRV_TEST) + 1);

    logic [1:0] ctrl_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic ack_r;
    fpi_test_t test_r;
    logic [TW-1:0] tcnt_r;
    logic [BW-1:0] bcnt_r;
    logic blink_r;
    logic [FW-1:0] fl_traffic_r, fl_acc_r, fl_port_r, fl_fwd_r;
    logic bridge;
    logic fail_cnt;
    logic [TW-1:0] test_len;
    logic [2:0] ev;
    logic access;

    function automatic logic [FW-1:0] stretch(input logic hit, input logic [FW-1:0] cnt);
        if (hit)
            return FW'(FLASH);
        else if (cnt != '0)
            return cnt - 1'b1;
        else
            return '0;
    endfunction

    assign bridge = ctrl_r[CTRL_BRIDGE];
    assign fail_cnt = bridge ? ctrl_board_fail : diag_fail;
    assign test_len = bridge ? TW'(BRG_TEST) : TW'(SRV_TEST);
    assign access = (avs_read | avs_write) && !ack_r;
    assign avs_waitrequest = access;
    assign irq = |(stat_r & mask_r);

    // bus handshake: one wait cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            ack_r <= 1'b0;
        else
            ack_r <= access;
    end

    // control and mask registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
            mask_r <= IRQ_RST;
        end else if (avs_write && ack_r && avs_byteenable[0]) begin
            if (avs_address == OFS_CTRL)
                ctrl_r <= avs_writedata[1:0];
            if (avs_address == OFS_MASK)
                mask_r <= avs_writedata[2:0];
        end
    end

    // sticky status, set wins over clear
    always_comb begin
        ev = '0;
        ev[ST_FAIL] = test_r == ST_TEST && fail_cnt;
        ev[ST_NOBOOT] = no_boot_source;
        ev[ST_TEST_DONE] = test_r == ST_TEST && tcnt_r >= test_len;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            stat_r <= IRQ_RST;
        else if (avs_write && ack_r && avs_address == OFS_STAT && avs_byteenable[0])
            stat_r <= (stat_r & ~avs_writedata[2:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end

    // read data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0;
        end else if (access) begin
            case (avs_address)
                OFS_CTRL: avs_readdata <= {30'h0, ctrl_r};
                OFS_STAT: avs_readdata <= {29'h0, stat_r};
                OFS_MASK: avs_readdata <= {29'h0, mask_r};
                OFS_LAMP: avs_readdata <= {25'h0, lamp_disk, lamp_self_test, lamp_boot,
                    lamp_forwarded, lamp_port_rx, lamp_accepted, lamp_traffic};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // self-test sequencer, counts up so a late variant write keeps its full length
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            test_r <= ST_TEST;
            tcnt_r <= '0;
        end else begin
            case (test_r)
                ST_TEST: begin
                    if (tcnt_r < test_len)
                        tcnt_r <= tcnt_r + 1'b1;
                    else if (fail_cnt)
                        test_r <= ST_FAILED;
                    else
                        test_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (no_boot_source)
                        test_r <= ST_NOSRC;
                end
                ST_NOSRC: begin
                    if (!no_boot_source)
                        test_r <= ST_RUN;
                end
                ST_FAILED: test_r <= ST_FAILED;
                default: test_r <= ST_TEST;
            endcase
        end
    end

    // blink timebase
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bcnt_r <= '0;
            blink_r <= 1'b0;
        end else if (bcnt_r == '0) begin
            bcnt_r <= BW'(BLINK - 1);
            blink_r <= ~blink_r;
        end else begin
            bcnt_r <= bcnt_r - 1'b1;
        end
    end

    // flash stretchers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fl_traffic_r <= '0;
            fl_acc_r <= '0;
            fl_port_r <= '0;
            fl_fwd_r <= '0;
        end else begin
            fl_traffic_r <= stretch(pkt_seen, fl_traffic_r);
            fl_acc_r <= stretch(bridge ? pkt_fwd_decision : pkt_own_addr, fl_acc_r);
            fl_port_r <= stretch(!bridge && port_rx, fl_port_r);
            fl_fwd_r <= stretch(bridge && pkt_forwarded, fl_fwd_r);
        end
    end

    // lamp drivers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lamp_traffic <= 1'b0;
            lamp_accepted <= 1'b0;
            lamp_port_rx <= 1'b0;
            lamp_forwarded <= 1'b0;
            lamp_boot <= 1'b0;
            lamp_self_test <= 1'b0;
            lamp_disk <= 1'b0;
        end else begin
            if (!bridge && ctrl_r[CTRL_RING])
                lamp_traffic <= ring_inserted;
            else
                lamp_traffic <= fl_traffic_r != '0;
            lamp_accepted <= fl_acc_r != '0;
            lamp_port_rx <= fl_port_r != '0;
            lamp_forwarded <= fl_fwd_r != '0;
            lamp_boot <= boot_active;
            lamp_disk <= disk_access;
            case (test_r)
                ST_TEST, ST_FAILED: lamp_self_test <= 1'b1;
                ST_NOSRC: lamp_self_test <= blink_r;
                default: lamp_self_test <= 1'b0;
            endcase
        end
    end

    chk_flash_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pkt_seen && !(ctrl_r[CTRL_RING] && !bridge) ##1 !$changed(ctrl_r) |=> lamp_traffic)
        else $error("traffic flash not shown");
    chk_disk_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        disk_access |=> lamp_disk)
        else $error("disk lamp not following access");
    chk_boot_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !boot_active |=> !lamp_boot)
        else $error("boot lamp lit without load");
    chk_ring_steady: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ctrl_r == 2'h2 && ring_inserted) |=> lamp_traffic)
        else $error("ring lamp not steady");
    chk_test_lit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_TEST && $past(test_r) == ST_TEST |=> lamp_self_test)
        else $error("self-test lamp dark during test");
    chk_fail_stays: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_FAILED |=> test_r == ST_FAILED ##1 lamp_self_test)
        else $error("failed lamp went dark");
    chk_pass_dark: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_RUN && !no_boot_source |=> !lamp_self_test)
        else $error("self-test lamp lit after pass");
    chk_fwd_server: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !bridge [*2] ##1 fl_fwd_r == '0 |=> !lamp_forwarded)
        else $error("forwarded lamp lit in server");
    chk_nosrc_enter: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_RUN && no_boot_source |=> test_r == ST_NOSRC)
        else $error("no boot source not flagged");
    chk_nosrc_leave: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_NOSRC && !no_boot_source |=> test_r == ST_RUN)
        else $error("blink kept after boot source returned");
    chk_disk_dark: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !disk_access |=> !lamp_disk)
        else $error("disk lamp lit without access");
    chk_boot_lit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        boot_active |=> lamp_boot)
        else $error("boot lamp dark during load");
    chk_ring_dark: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !bridge && ctrl_r[CTRL_RING] && !ring_inserted |=> !lamp_traffic)
        else $error("ring lamp lit while not inserted");
    chk_own_flash: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !bridge && pkt_own_addr |-> ##2 lamp_accepted)
        else $error("accepted lamp missed own packet");
    chk_fwd_accept: assert property (@(posedge clk_sys) disable iff (!rst_b)
        bridge && pkt_fwd_decision |-> ##2 lamp_accepted)
        else $error("accepted lamp missed forward decision");
    chk_fwd_flash: assert property (@(posedge clk_sys) disable iff (!rst_b)
        bridge && pkt_forwarded |-> ##2 lamp_forwarded)
        else $error("forwarded lamp missed packet");
    chk_port_flash: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !bridge && port_rx |-> ##2 lamp_port_rx)
        else $error("port lamp missed receive");
    chk_net_flash: assert property (@(posedge clk_sys) disable iff (!rst_b)
        bridge && pkt_seen ##1 bridge |=> lamp_traffic)
        else $error("bridge traffic lamp missed packet");
    chk_acc_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(lamp_accepted) |-> lamp_accepted [*8])
        else $error("accepted flash too short");
    chk_fwd_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(lamp_forwarded) |-> lamp_forwarded [*8])
        else $error("forwarded flash too short");
    chk_port_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(lamp_port_rx) |-> lamp_port_rx [*8])
        else $error("port flash too short");
    chk_test_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rst_b) |=> lamp_self_test)
        else $error("self-test lamp dark after reset");
    chk_fail_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_TEST && fail_cnt |=> stat_r[ST_FAIL])
        else $error("test failure not recorded");
    chk_pass_run: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_TEST && tcnt_r >= test_len && !fail_cnt |=> test_r == ST_RUN)
        else $error("passed test did not end");
    chk_fail_enter: assert property (@(posedge clk_sys) disable iff (!rst_b)
        test_r == ST_TEST && tcnt_r >= test_len && fail_cnt |=> test_r == ST_FAILED)
        else $error("failed test not held");
endmodule // fpi_panel

/* File: fpi_pkg.sv */
package fpi_pkg;
    // timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SRV_TEST_S = 10;
    localparam int unsigned BRG_TEST_S = 12;
    localparam longint unsigned SRV_TEST_CYC = longint'(SRV_TEST_S) * CLK_HZ;
    localparam longint unsigned BRG_TEST_CYC = longint'(BRG_TEST_S) * CLK_HZ;
    localparam int unsigned FLASH_MS = 50;
    localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
    // register map
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_LAMP = 4'hC;
    // ctrl bits
    localparam int CTRL_BRIDGE = 0;
    localparam int CTRL_RING = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // status bits
    localparam int ST_FAIL = 0;
    localparam int ST_NOBOOT = 1;
    localparam int ST_TEST_DONE = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam int NUM_LAMPS = 7;
    typedef enum logic [1:0] {ST_TEST, ST_RUN, ST_FAILED, ST_NOSRC} fpi_test_t;
endpackage

/* File: fpi_lamp_view.sv */
module fpi_lamp_view (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // lamps seen by the operator
    input wire logic [6:0] lamps,
    input wire logic clr,
    output logic [6:0] lit_seen,
    output logic [6:0] dark_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // remembers which lamps were seen lit or dark
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lit_seen <= 7'h00;
            dark_seen <= 7'h00;
        end else if (clr) begin
            lit_seen <= 7'h00;
            dark_seen <= 7'h00;
        end else begin
            lit_seen <= lit_seen | lamps;
            dark_seen <= dark_seen | ~lamps;
        end
    end
endmodule // fpi_lamp_view

/* File: tb_top.sv */
module tb_top;
    import fpi_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'h0, wr = 1'h0, clr = 1'h0;
    logic [31:0] wd = 32'h0, rdat, got;
    logic wq, irq;
    logic [4:0] ev = 5'h00;
    logic ring = 1'h0, boot = 1'h0, dfail = 1'h0, bfail = 1'h0, nob = 1'h0, disk = 1'h0;
    wire logic [6:0] lamps;
    logic [6:0] lit, dark;
    int n_mismatch = 0, compares = 0, cyc = 0, tc = 0;
    always #12.5 clk_sys = ~clk_sys;
    fpi_panel #(.SRV_TEST(400), .BRG_TEST(480), .FLASH(8), .BLINK(3)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wq), .irq(irq),
        .pkt_seen(ev[0]), .ring_inserted(ring), .pkt_own_addr(ev[1]),
        .port_rx(ev[2]), .pkt_fwd_decision(ev[3]), .pkt_forwarded(ev[4]),
        .boot_active(boot), .diag_fail(dfail), .ctrl_board_fail(bfail),
        .no_boot_source(nob), .disk_access(disk), .lamp_traffic(lamps[0]),
        .lamp_accepted(lamps[1]), .lamp_port_rx(lamps[2]), .lamp_forwarded(lamps[3]),
        .lamp_boot(lamps[4]), .lamp_self_test(lamps[5]), .lamp_disk(lamps[6]));
    fpi_lamp_view view_u (.clk_sys(clk_sys), .rst_b(rst_b), .lamps(lamps), .clr(clr),
        .lit_seen(lit), .dark_seen(dark));
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        tc <= rst_b ? tc + 1 : 0;
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic til(int n);
        while (tc < n) @(posedge clk_sys);
    endtask
    task automatic rst();
        rst_b <= 1'h0;
        wt(2);
        rst_b <= 1'h1;
        wt(2);
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_sys);
        end while (wq);
        got = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    // two pulses, the second retriggering the flash
    task automatic flash(int i, int l);
        ev[i] <= 1'h1;
        @(posedge clk_sys);
        ev[i] <= 1'h0;
        wt(3);
        chk(lamps[l], 32'h1);
        wt(3);
        ev[i] <= 1'h1;
        @(posedge clk_sys);
        ev[i] <= 1'h0;
        wt(6);
        chk(lamps[l], 32'h1);
        wt(14);
        chk(lamps[l], 32'h0);
    endtask
    // pulses after which the view shows what lit
    task automatic quiet(logic [4:0] p);
        clr <= 1'h1;
        ev <= p;
        @(posedge clk_sys);
        clr <= 1'h0;
        ev <= 5'h00;
        wt(6);
    endtask
    initial begin
        rst();
        chk(lamps[5], 32'h1);
        bus(1'h0, OFS_LAMP, 32'h0);
        chk(got, 32'h20);
        bus(1'h0, 4'h1, 32'h0);
        chk(got, 32'h0);
        flash(0, 0);
        flash(1, 1);
        flash(2, 2);
        quiet(5'h19);
        chk(lit[0], 32'h1);
        chk(lit[1], 32'h0);
        chk(lit[3], 32'h0);
        boot <= 1'h1;
        disk <= 1'h1;
        wt(4);
        chk({25'h0, lamps & 7'h50}, 32'h50);
        boot <= 1'h0;
        disk <= 1'h0;
        wt(4);
        chk({25'h0, lamps & 7'h50}, 32'h0);
        bus(1'h1, OFS_MASK, 32'h4);
        til(370);
        chk(lamps[5], 32'h1);
        chk(irq, 32'h0);
        til(430);
        chk(lamps[5], 32'h0);
        chk(irq, 32'h1);
        bus(1'h0, OFS_STAT, 32'h0);
        chk(got, 32'h4);
        bus(1'h1, OFS_STAT, 32'h4);
        wt(1);
        chk(irq, 32'h0);
        bus(1'h1, OFS_CTRL, 32'h2);
        ring <= 1'h1;
        wt(20);
        chk(lamps[0], 32'h1);
        wt(20);
        chk(lamps[0], 32'h1);
        ring <= 1'h0;
        nob <= 1'h1;
        wt(4);
        chk(lamps[0], 32'h0);
        clr <= 1'h1;
        @(posedge clk_sys);
        clr <= 1'h0;
        wt(8);
        chk(lit[5] & dark[5], 32'h1);
        nob <= 1'h0;
        wt(3);
        chk(lamps[5], 32'h0);
        rst();
        dfail <= 1'h1;
        til(470);
        chk(lamps[5], 32'h1);
        bus(1'h0, OFS_STAT, 32'h0);
        chk(got[0], 32'h1);
        rst();
        bus(1'h1, OFS_CTRL, 32'h1);
        til(450);
        chk(lamps[5], 32'h1);
        til(510);
        chk(lamps[5], 32'h0);
        dfail <= 1'h0;
        flash(0, 0);
        flash(3, 1);
        flash(4, 3);
        quiet(5'h07);
        chk(lit[0], 32'h1);
        chk(lit[1], 32'h0);
        chk(lit[2], 32'h0);
        rst();
        bus(1'h1, OFS_CTRL, 32'h1);
        bfail <= 1'h1;
        til(530);
        chk(lamps[5], 32'h1);
        final_report();
    end
endmodule // tb_top
